// [bridge_legacy_decode_error_ctl_defs.vh]
// constants for the legacy decode and error control block
`ifndef BRIDGE_LEGACY_DECODE_ERROR_CTL_DEFS_VH
`define BRIDGE_LEGACY_DECODE_ERROR_CTL_DEFS_VH

// bit positions of the control options in the bridge control word
`define CTL_VIDEO_EN_BIT       5'd19
`define CTL_ISA_FILTER_BIT     5'd18
`define CTL_SYSERR_FWD_BIT     5'd17
`define CTL_PARITY_RESP_BIT    5'd16

// reset value of every control option
`define CTL_RESET_VALUE        1'b0

// legacy video memory window
`define VIDEO_MEM_LOW          32'h000a0000
`define VIDEO_MEM_HIGH         32'h000bffff

// legacy video io windows on the low ten address bits
`define VIDEO_IO_A_LOW         10'h3b0
`define VIDEO_IO_A_HIGH        10'h3bb
`define VIDEO_IO_B_LOW         10'h0c0
`define VIDEO_IO_B_HIGH        10'h3df

// upper io address bits that must be zero
`define IO_UPPER_ZERO          16'h0000

// isa alias: block offset below this is the first 256 bytes
`define ISA_ALIAS_LOW_LIMIT    10'h100

`endif

// [bridge_legacy_decode_error_ctl.v]
// legacy video decode, isa io filter, serr forward and parity response
// What this block does
// - video on: claim upstream memory a0000-bffff
// - video on: claim upstream video io ranges
// - video decode needs io and memory enables
// - video on: never claim video cycles from downstream bus
// - video off: ignore unless window and no filter
// - filter off: forward all io in window
// - filter on: drop upstream isa alias io
// - filter on: forward downstream alias io upstream
// - forward serr only with both enables set
// - parity response off: no perr, no report
// - parity response on: drive perr, set bit
// - address parity serr only with response on
`timescale 1ns/10ps
`default_nettype none
`include "bridge_legacy_decode_error_ctl_defs.vh"

module bridge_legacy_decode_error_ctl (
	// clock and reset
	input  wire        clock_i,
	input  wire        rst_b_i,
	// control option writes
	input  wire        ctl_write_i,
	input  wire [31:0] ctl_wdata_i,
	// upstream command enables
	input  wire        io_space_enable_i,
	input  wire        mem_space_enable_i,
	input  wire        upstream_serr_driver_enable_i,
	// upstream bus decode request
	input  wire        up_valid_i,
	input  wire        up_is_io_i,
	input  wire [31:0] up_addr_i,
	input  wire        up_in_io_window_i,
	// downstream bus decode request
	input  wire        dn_valid_i,
	input  wire        dn_is_io_i,
	input  wire [31:0] dn_addr_i,
	input  wire        dn_in_io_window_i,
	// downstream error events
	input  wire        downstream_system_error_line_i,
	input  wire        dn_data_parity_err_i,
	input  wire        dn_addr_parity_err_i,
	input  wire        dn_parity_report_qualify_i,
	// decode answers
	output wire        up_claim_o,
	output wire        dn_claim_o,
	// error outputs, serr and perr open drain, oe low drives low
	output wire        upstream_system_error_line_o,
	output wire        upstream_system_error_line_oe_b_o,
	output wire        downstream_parity_error_line_o,
	output wire        downstream_parity_error_line_oe_b_o,
	output wire        data_parity_reported_set_o,
	// option readback
	output wire [3:0]  ctl_rdata_o
);

	////////////////////////////////////////////////////////////////////
	// helper functions

	// offset in 1KB block lies in last 768 bytes
	function isa_alias;
		input [31:0] a;
		begin
			isa_alias = (a[9:0] >= `ISA_ALIAS_LOW_LIMIT);
		end
	endfunction

	// address hits the legacy video io ranges
	function video_io_hit;
		input [31:0] a;
		begin
			video_io_hit = (a[31:16] == `IO_UPPER_ZERO) &&
				(((a[9:0] >= `VIDEO_IO_A_LOW) &&
				  (a[9:0] <= `VIDEO_IO_A_HIGH)) ||
				 ((a[9:0] >= `VIDEO_IO_B_LOW) &&
				  (a[9:0] <= `VIDEO_IO_B_HIGH)));
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// control option bits

	reg video_en;      // legacy video positive decode
	reg legacy_io_filter_enable;
	reg system_error_forward_enable;
	reg downstream_parity_response_enable;

	// options load from the control word and clear on reset
	// a write replaces all four options at once, there is no
	// per-bit mask, so software must write back what it keeps
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			video_en                          <= `CTL_RESET_VALUE;
			legacy_io_filter_enable           <= `CTL_RESET_VALUE;
			system_error_forward_enable       <= `CTL_RESET_VALUE;
			downstream_parity_response_enable <= `CTL_RESET_VALUE;
		end else if (ctl_write_i) begin
			video_en                          <= ctl_wdata_i[`CTL_VIDEO_EN_BIT];
			legacy_io_filter_enable           <= ctl_wdata_i[`CTL_ISA_FILTER_BIT];
			system_error_forward_enable       <= ctl_wdata_i[`CTL_SYSERR_FWD_BIT];
			downstream_parity_response_enable <= ctl_wdata_i[`CTL_PARITY_RESP_BIT];
		end
	end

	assign ctl_rdata_o = {video_en, legacy_io_filter_enable,
		system_error_forward_enable, downstream_parity_response_enable};

	////////////////////////////////////////////////////////////////////
	// error pin synchronisers

	reg [1:0] serr_sync_b;  // downstream serr, active low
	reg [2:0] evt_sync0;    // first stage of event inputs
	reg [2:0] evt_sync1;    // second stage of event inputs

	// two flops on every error input from the downstream pins
	// the error pins are asynchronous to this clock, so only the second
	// stage is ever read; this costs two cycles of error latency
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			serr_sync_b <= 2'h3;
			evt_sync0   <= 3'h0;
			evt_sync1   <= 3'h0;
		end else begin
			serr_sync_b <= {serr_sync_b[0], downstream_system_error_line_i};
			evt_sync0   <= {dn_data_parity_err_i, dn_addr_parity_err_i,
				dn_parity_report_qualify_i};
			evt_sync1   <= evt_sync0;
		end
	end

	wire dn_serr_seen   = ~serr_sync_b[1];
	wire data_par_err   = evt_sync1[2];
	wire addr_par_err   = evt_sync1[1];
	wire report_qualify = evt_sync1[0];

	////////////////////////////////////////////////////////////////////
	// address decode (combinational handshake answers)

	reg up_claim;  // upstream cycle forwarded downstream
	reg dn_claim;  // downstream cycle forwarded upstream
	reg video_hit; // upstream cycle in legacy video space

	// upstream claim: video decode first, then io window with filter
	// with video decode off, a video range io cycle inside the window
	// passes only while the filter is off; with the filter on it is
	// dropped even where its offset is not an alias
	always @* begin
		video_hit = up_is_io_i ? video_io_hit(up_addr_i) :
			((up_addr_i >= `VIDEO_MEM_LOW) &&
			 (up_addr_i <= `VIDEO_MEM_HIGH));
		up_claim = 1'b0;
		if (video_en && io_space_enable_i && mem_space_enable_i &&
				video_hit) begin
			up_claim = 1'b1;
		end else if (up_is_io_i && up_in_io_window_i) begin
			if (!legacy_io_filter_enable) begin
				up_claim = 1'b1;
			end else if (video_hit) begin
				up_claim = 1'b0;
			end else if (!((up_addr_i[31:16] == `IO_UPPER_ZERO) &&
					isa_alias(up_addr_i))) begin
				up_claim = 1'b1;
			end
		end
		up_claim = up_claim && up_valid_i;
	end

	// downstream claim: alias io goes up under filter, video io never while video_en is set
	// downstream memory cycles are left to the memory window decoder
	// and are never claimed here
	always @* begin
		dn_claim = 1'b0;
		if (dn_valid_i && dn_is_io_i) begin
			if (video_en && video_io_hit(dn_addr_i)) begin
				dn_claim = 1'b0;
			end else if (legacy_io_filter_enable &&
					isa_alias(dn_addr_i)) begin
				dn_claim = 1'b1;
			end else if (!dn_in_io_window_i) begin
				dn_claim = 1'b1;
			end
		end
	end

	assign up_claim_o = up_claim;
	assign dn_claim_o = dn_claim;

	////////////////////////////////////////////////////////////////////
	// error responses

	reg up_serr_drive;   // pull upstream serr low
	reg dn_perr_drive;   // pull downstream perr low
	reg par_report_set;  // level held high to set data parity reported bit

	// serr forward, parity response and address parity report
	// every answer is a level that follows its synchronised cause, so
	// the line is released three cycles after the cause goes away
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			up_serr_drive  <= 1'b0;
			dn_perr_drive  <= 1'b0;
			par_report_set <= 1'b0;
		end else begin
			up_serr_drive <= upstream_serr_driver_enable_i &&
				((system_error_forward_enable && dn_serr_seen) ||
				 (downstream_parity_response_enable &&
				  addr_par_err));
			dn_perr_drive <= downstream_parity_response_enable &&
				data_par_err;
			par_report_set <= downstream_parity_response_enable &&
				data_par_err && report_qualify;
		end
	end

	// open drain: the value is always low, only the enable moves
	assign upstream_system_error_line_o        = 1'b0;
	assign upstream_system_error_line_oe_b_o   = ~up_serr_drive;
	assign downstream_parity_error_line_o      = 1'b0;
	assign downstream_parity_error_line_oe_b_o = ~dn_perr_drive;
	assign data_parity_reported_set_o          = par_report_set;

endmodule
`default_nettype wire

// [far_agents.sv]
// far side bus agents: error pin driver and pulled-up open-drain lines
`timescale 1ns/10ps
`default_nettype none
module far_agents (
	// clock and requests from the bench
	input  wire logic clock_i,
	input  wire logic serr_req_i,
	// open-drain outputs of the bridge
	input  wire logic up_oe_b_i, up_val_i, dn_oe_b_i, dn_val_i,
	// resolved pin levels
	output var  logic serr_pin_o,
	output wire logic up_line_o, dn_line_o
);
	// error pin goes low a cycle after the request, pulled up when idle
	initial serr_pin_o = 1'b1;
	always @(posedge clock_i) serr_pin_o <= #2 ~serr_req_i;
	// pull-ups win unless the bridge enables its driver
	assign up_line_o = up_oe_b_i ? 1'b1 : up_val_i;
	assign dn_line_o = dn_oe_b_i ? 1'b1 : dn_val_i;
endmodule
`default_nettype wire

// [bridge_legacy_decode_error_ctl_checker.sv]
// port assertions for the legacy decode and error control block
`timescale 1ns/10ps
`default_nettype none
module legacy_ctl_checker (
	input wire logic clock_i, rst_b_i, io_space_enable_i, mem_space_enable_i,
	input wire logic upstream_serr_driver_enable_i, up_valid_i, up_is_io_i,
	input wire logic dn_valid_i, dn_is_io_i, downstream_system_error_line_i,
	input wire logic dn_data_parity_err_i, dn_addr_parity_err_i,
	input wire logic up_claim_o, dn_claim_o, data_parity_reported_set_o,
	input wire logic upstream_system_error_line_oe_b_o,
	input wire logic downstream_parity_error_line_oe_b_o,
	input wire logic [31:0] up_addr_i, dn_addr_i,
	input wire logic [3:0]  ctl_rdata_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	// short aliases of options, enables and open-drain enables
	wire logic vid = ctl_rdata_o[3] && io_space_enable_i && mem_space_enable_i;
	wire logic fwd = ctl_rdata_o[1];
	wire logic rsp = ctl_rdata_o[0];
	wire logic drv = upstream_serr_driver_enable_i;
	wire logic s_ob = upstream_system_error_line_oe_b_o;
	wire logic p_ob = downstream_parity_error_line_oe_b_o;
	wire logic up_m = up_valid_i && !up_is_io_i && up_addr_i >= 32'h000a0000
		&& up_addr_i <= 32'h000bffff;
	wire logic dn_m = dn_valid_i && !dn_is_io_i && dn_addr_i >= 32'h000a0000
		&& dn_addr_i <= 32'h000bffff;
	property p_mem; up_m && vid |-> up_claim_o; endproperty
	a_mem: assert property (p_mem) else $error("video memory not claimed");
	property p_gate; up_valid_i && !up_is_io_i && !vid |-> !up_claim_o; endproperty
	a_gate: assert property (p_gate) else $error("memory claimed ungated");
	property p_dn; dn_m |-> !dn_claim_o; endproperty
	a_dn: assert property (p_dn) else $error("downstream video claimed");
	property p_fwd; (!downstream_system_error_line_i && fwd && drv)[*4] |=> !s_ob; endproperty
	a_fwd: assert property (p_fwd) else $error("error not forwarded");
	property p_soff; (!fwd && !rsp || !drv)[*4] |=> s_ob; endproperty
	a_soff: assert property (p_soff) else $error("error line driven");
	property p_pon; (dn_data_parity_err_i && rsp)[*4] |=> !p_ob; endproperty
	a_pon: assert property (p_pon) else $error("parity line not driven");
	property p_poff; (!rsp)[*4] |=> p_ob && !data_parity_reported_set_o; endproperty
	a_poff: assert property (p_poff) else $error("parity answer off");
	property p_adr; (dn_addr_parity_err_i && rsp && drv)[*4] |=> !s_ob; endproperty
	a_adr: assert property (p_adr) else $error("address error lost");
endmodule
bind bridge_legacy_decode_error_ctl legacy_ctl_checker u_chk (.*);
`default_nettype wire

// [tb.sv]
// self-checking bench for the legacy decode and error control block
`timescale 1ns/10ps
`default_nettype none
module tb;
	// stimulus and observed signals
	logic clock_i, rst_b_i, wr_en, io_en, mem_en, drv, up_v, up_io, up_w;
	logic dn_v, dn_io, dn_w, serr_req, d_err, a_err, qual;
	logic [31:0] wdata, up_a, dn_a;
	wire logic up_c, dn_c, s_pin, s_val, s_ob, p_val, p_ob, set, up_l, dn_l;
	wire logic [3:0] rdata;
	int err_total, checked;
	bridge_legacy_decode_error_ctl u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
		.ctl_write_i(wr_en), .ctl_wdata_i(wdata), .io_space_enable_i(io_en),
		.mem_space_enable_i(mem_en), .upstream_serr_driver_enable_i(drv),
		.up_valid_i(up_v), .up_is_io_i(up_io), .up_addr_i(up_a),
		.up_in_io_window_i(up_w), .dn_valid_i(dn_v), .dn_is_io_i(dn_io),
		.dn_addr_i(dn_a), .dn_in_io_window_i(dn_w),
		.downstream_system_error_line_i(s_pin), .dn_data_parity_err_i(d_err),
		.dn_addr_parity_err_i(a_err), .dn_parity_report_qualify_i(qual),
		.up_claim_o(up_c), .dn_claim_o(dn_c), .upstream_system_error_line_o(s_val),
		.upstream_system_error_line_oe_b_o(s_ob),
		.downstream_parity_error_line_o(p_val),
		.downstream_parity_error_line_oe_b_o(p_ob),
		.data_parity_reported_set_o(set), .ctl_rdata_o(rdata));
	far_agents u_far (.clock_i(clock_i), .serr_req_i(serr_req), .up_oe_b_i(s_ob),
		.up_val_i(s_val), .dn_oe_b_i(p_ob), .dn_val_i(p_val),
		.serr_pin_o(s_pin), .up_line_o(up_l), .dn_line_o(dn_l));
	// compare and count
	task automatic chk(input logic [5:0] got, exp, input string what);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	// write the options, then read them back
	task automatic wr(input logic [3:0] v);
		@(posedge clock_i) #2 wr_en = 1'b1;
		wdata = {12'h000, v, 16'h0000};
		@(posedge clock_i) #2 wr_en = 1'b0;
		chk({2'b00, rdata}, {2'b00, v}, "option readback");
	endtask
	// one decode request on either bus, claim compared once settled
	task automatic dec(input logic dn, io, input logic [31:0] a, input logic w, e);
		@(posedge clock_i) #2;
		if (dn) {dn_v, dn_io, dn_a, dn_w} = {1'b1, io, a, w};
		else {up_v, up_io, up_a, up_w} = {1'b1, io, a, w};
		#1 chk({5'h00, dn ? dn_c : up_c}, {5'h00, e}, "claim");
	endtask
	// error events, then the three error outputs after the sync latency
	task automatic ev(input logic [4:0] in, input logic [2:0] e);
		@(posedge clock_i) #2 {drv, serr_req, d_err, a_err, qual} = in;
		repeat (6) @(posedge clock_i);
		#2 chk({3'h0, up_l, dn_l, set}, {3'h0, e}, "error outputs");
	endtask
	task automatic give_verdict;
		$display("comparisons %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end
	initial begin
		#100000 err_total++;
		give_verdict;
	end
	initial begin
		{wr_en, io_en, mem_en, drv, up_v, up_io, up_w, dn_v, dn_io, dn_w} = 0;
		{serr_req, d_err, a_err, qual, wdata, up_a, dn_a, rst_b_i} = 0;
		repeat (20) @(posedge clock_i);
		#2 rst_b_i = 1'b1;
		chk({rdata, up_l, dn_l}, 6'h03, "reset state");
		{io_en, mem_en} = 2'b11;
		wr(4'h8);
		dec(0, 0, 32'h000a0000, 0, 1);
		dec(0, 0, 32'h000bffff, 0, 1);
		dec(0, 0, 32'h0009ffff, 0, 0);
		dec(0, 1, 32'h0000fcc0, 0, 1);
		dec(0, 1, 32'h000003e0, 0, 0);
		dec(0, 1, 32'h000000bf, 0, 0);
		dec(0, 1, 32'h000103b0, 0, 0);
		dec(1, 1, 32'h000003b0, 0, 0);
		dec(1, 0, 32'h000a0000, 0, 0);
		@(posedge clock_i) #2 io_en = 1'b0;
		dec(0, 0, 32'h000a0000, 0, 0);
		wr(4'h0);
		dec(0, 1, 32'h000003b0, 0, 0);
		dec(0, 1, 32'h000003b0, 1, 1);
		wr(4'h4);
		dec(0, 1, 32'h00000100, 1, 0);
		dec(0, 1, 32'h000004ff, 1, 0);
		dec(0, 1, 32'h000004bf, 1, 1);
		dec(0, 1, 32'h00010100, 1, 1);
		dec(1, 1, 32'h00000500, 1, 1);
		dec(1, 1, 32'h000004bf, 1, 0);
		wr(4'h2);
		ev(5'b11000, 3'b010);
		ev(5'b01000, 3'b110);
		wr(4'h0);
		ev(5'b11000, 3'b110);
		ev(5'b10111, 3'b110);
		wr(4'h1);
		ev(5'b10101, 3'b101);
		ev(5'b00100, 3'b100);
		ev(5'b10010, 3'b010);
		wr(4'hf);
		give_verdict;
	end
endmodule
`default_nettype wire
